/* File: hdl/gotc_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "gotc_defines.vh"
// How it works
// - Four 11-bit trim converter codes, one per baseband input pin.
// - Codes span 64 to 2047; code 0 shuts that converter down.
// - Coarse gain from five low bits of gain register selects hardwired code.
// - Coarse gain in dB is minus the field value, held at -19 for field values above 19.
// - Sixteen 0.1 dB fine steps from fine register when correction bit clear.
// - At gain ratio 128, neighbouring fine steps stay at least two codes apart at every coarse code.
// - With correction on, fine selection comes from the thermometer code.
// - Thermometer code is four bits, minus 30 to 120 C in 10 C steps.
// - Update-select clear: thermometer code follows threshold crossings directly.
// - Update-select set: code and compensation change only on strobe rising edge.
// - Readback register returns the four-bit thermometer code.
// - After enable rises with update-select set, readback holds 7 until strobed.
// - On update-select 0 to 1, readback shows last strobe capture.
// - Readback is not live under correction or unstrobed strobe mode.
// - Analog gain enable bit drives the analog control output.
// - Offset registers are 8 bits, reset 128, meaning zero offset.
// - Offset splits positive and negative converter codes of a channel.
// - Q-off bit switches off the Q converters; default on.
// - Soft reset bit restores defaults and clears itself after one clock.
// - Gain ratio 128 gives equal I and Q gain; above favours I.
module gotc_top (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Chip enable pin, acts as power-up reset.
  input wire enable_pin,
  // Register port.
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Thermometer and strobe.
  input wire [3:0] thermo_live_code,
  input wire thermo_update_strobe,
  // Analog control.
  output reg analog_gain_on,
  // Converter codes.
  output reg [10:0] i_positive_input,
  output reg [10:0] i_negative_input,
  output reg [10:0] q_positive_input,
  output reg [10:0] q_negative_input
);
  reg [7:0] gain_control;
  reg [7:0] i_offset_trim;
  reg [7:0] q_offset_trim;
  reg [7:0] gain_ratio;
  reg [7:0] fine_gain_trim;
  reg [7:0] mode_control;
  reg [3:0] thermo_code;
  reg [3:0] strobe_capture;
  reg strobe_prev;
  reg en_prev;
  reg [1:0] srst_count;
  reg [3:0] thermo_prev_s;
  reg [3:0] thermo_stable;
  reg [3:0] temp_readback;
  localparam [31:0] SRST_FULL = `GOTC_SRST_CYCLES;
  wire strobe_sync;
  wire en_sync;
  wire [3:0] thermo_s;
  wire update_select;
  wire temp_correction_on;
  wire strobe_rise;
  wire enable_rise;
  wire [3:0] fine_gain_code;
  wire [10:0] next_ip;
  wire [10:0] next_im;
  wire [10:0] next_qp;
  wire [10:0] next_qm;
  reg [7:0] next_rdata;

  assign update_select = gain_control[`GOTC_BIT_UPDATE_SELECT];
  assign temp_correction_on = mode_control[`GOTC_BIT_TEMP_CORR];

  // The strobe, enable and thermometer pins each pass two flip-flops before use; the register port does not.
  gotc_sync u_sync_strobe (
    .clock(clock),
    .rst(rst),
    .din(thermo_update_strobe),
    .dout(strobe_sync)
  );
  gotc_sync u_sync_en (
    .clock(clock),
    .rst(rst),
    .din(enable_pin),
    .dout(en_sync)
  );
  // Thermometer bits settle per bit; a bit may skew by a cycle across a threshold, so a torn word is filtered out below.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_thermo_sync
      gotc_sync u_sync_t (
        .clock(clock),
        .rst(rst),
        .din(thermo_live_code[g]),
        .dout(thermo_s[g])
      );
    end
  endgenerate

  assign strobe_rise = strobe_sync & ~strobe_prev;
  assign enable_rise = en_sync & ~en_prev;

  // Registers, with soft reset and enable acting as reset.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_control <= `GOTC_RST_GAIN_CONTROL;
      i_offset_trim <= `GOTC_RST_OFFSET;
      q_offset_trim <= `GOTC_RST_OFFSET;
      gain_ratio <= `GOTC_RST_GAIN_RATIO;
      fine_gain_trim <= `GOTC_RST_FINE_GAIN;
      mode_control <= `GOTC_RST_MODE;
      srst_count <= 2'h0;
    end else if (srst_count != 2'h0) begin
      // Hold defaults while the self-clearing reset bit is high.
      gain_control <= `GOTC_RST_GAIN_CONTROL;
      i_offset_trim <= `GOTC_RST_OFFSET;
      q_offset_trim <= `GOTC_RST_OFFSET;
      gain_ratio <= `GOTC_RST_GAIN_RATIO;
      fine_gain_trim <= `GOTC_RST_FINE_GAIN;
      mode_control <= `GOTC_RST_MODE;
      srst_count <= srst_count - 2'h1;
    end else if (!en_sync) begin
      // Disabled chip sits at defaults and ignores writes.
      gain_control <= `GOTC_RST_GAIN_CONTROL;
      i_offset_trim <= `GOTC_RST_OFFSET;
      q_offset_trim <= `GOTC_RST_OFFSET;
      gain_ratio <= `GOTC_RST_GAIN_RATIO;
      fine_gain_trim <= `GOTC_RST_FINE_GAIN;
      mode_control <= `GOTC_RST_MODE;
    end else if (reg_write) begin
      case (reg_addr)
        `GOTC_ADDR_GAIN_CONTROL: gain_control <= reg_wdata;
        `GOTC_ADDR_I_OFFSET: i_offset_trim <= reg_wdata;
        `GOTC_ADDR_Q_OFFSET: q_offset_trim <= reg_wdata;
        `GOTC_ADDR_GAIN_RATIO: gain_ratio <= reg_wdata;
        `GOTC_ADDR_FINE_GAIN: fine_gain_trim <= reg_wdata;
        `GOTC_ADDR_MODE: begin
          mode_control <= reg_wdata;
          if (reg_wdata[`GOTC_BIT_SOFT_RESET]) begin
            srst_count <= SRST_FULL[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Thermometer code used by the gain path and the strobe capture.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      thermo_code <= `GOTC_RST_TEMP;
      strobe_capture <= `GOTC_RST_TEMP;
      temp_readback <= `GOTC_RST_TEMP;
      thermo_prev_s <= 4'h0;
      thermo_stable <= 4'h0;
      strobe_prev <= 1'b0;
      en_prev <= 1'b0;
    end else begin
      strobe_prev <= strobe_sync;
      en_prev <= en_sync;
      thermo_prev_s <= thermo_s;
      // Bits are synchronised one by one, so a word in mid-change can be torn for a cycle.
      // Only a code seen twice in a row is taken, at the cost of one more cycle of lag.
      if (thermo_s == thermo_prev_s) begin
        thermo_stable <= thermo_s;
      end
      if (strobe_rise) begin
        strobe_capture <= thermo_stable;
      end
      if (enable_rise && update_select) begin
        thermo_code <= `GOTC_RST_TEMP;
        strobe_capture <= `GOTC_RST_TEMP;
      end else if (!update_select) begin
        thermo_code <= thermo_stable;
      end else if (strobe_rise) begin
        thermo_code <= thermo_stable;
      end else if (update_select && thermo_code != strobe_capture && !strobe_rise && en_prev && !enable_rise) begin
        // On a 0 to 1 switch, show the last strobe capture.
        thermo_code <= strobe_capture;
      end
      // Readback freezes while correction runs, so it never shows the live code then.
      if (!temp_correction_on) begin
        temp_readback <= thermo_code;
      end
    end
  end

  // Fine selection source; thermometer replaces the field under correction.
  assign fine_gain_code = temp_correction_on ? thermo_code : fine_gain_trim[3:0];

  gotc_dac_code u_i_code (
    .coarse_gain_code(gain_control[4:0]),
    .fine_gain_code(fine_gain_code),
    .offset_trim_value(i_offset_trim),
    .gain_ratio_value(gain_ratio),
    .is_i_channel(1'b1),
    .channel_off(~en_sync),
    .pos_code(next_ip),
    .neg_code(next_im)
  );
  gotc_dac_code u_q_code (
    .coarse_gain_code(gain_control[4:0]),
    .fine_gain_code(fine_gain_code),
    .offset_trim_value(q_offset_trim),
    .gain_ratio_value(gain_ratio),
    .is_i_channel(1'b0),
    .channel_off(~en_sync | gain_control[`GOTC_BIT_Q_OFF]),
    .pos_code(next_qp),
    .neg_code(next_qm)
  );

  // Readback mux; unmapped addresses read zero.
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `GOTC_ADDR_GAIN_CONTROL: next_rdata = gain_control;
      `GOTC_ADDR_I_OFFSET: next_rdata = i_offset_trim;
      `GOTC_ADDR_Q_OFFSET: next_rdata = q_offset_trim;
      `GOTC_ADDR_GAIN_RATIO: next_rdata = gain_ratio;
      `GOTC_ADDR_FINE_GAIN: next_rdata = fine_gain_trim;
      `GOTC_ADDR_MODE: next_rdata = {4'h0, (srst_count != 2'h0), mode_control[2:0]};
      `GOTC_ADDR_TEMP_READ: next_rdata = {4'h0, temp_readback};
      default: next_rdata = 8'h00;
    endcase
  end

  // Outputs registered so downstream converters never see glitching codes.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      analog_gain_on <= 1'b0;
      i_positive_input <= `GOTC_DAC_OFF;
      i_negative_input <= `GOTC_DAC_OFF;
      q_positive_input <= `GOTC_DAC_OFF;
      q_negative_input <= `GOTC_DAC_OFF;
    end else begin
      reg_rdata <= next_rdata;
      analog_gain_on <= gain_control[`GOTC_BIT_ANALOG_GAIN];
      i_positive_input <= next_ip;
      i_negative_input <= next_im;
      q_positive_input <= next_qp;
      q_negative_input <= next_qm;
    end
  end
endmodule // gotc_top
`default_nettype wire

/* File: hdl/gotc_defines.vh */
`ifndef GOTC_DEFINES_VH
`define GOTC_DEFINES_VH
// Register addresses.
`define GOTC_ADDR_GAIN_CONTROL 8'h01
`define GOTC_ADDR_I_OFFSET 8'h02
`define GOTC_ADDR_Q_OFFSET 8'h03
`define GOTC_ADDR_GAIN_RATIO 8'h04
`define GOTC_ADDR_FINE_GAIN 8'h07
`define GOTC_ADDR_MODE 8'h08
`define GOTC_ADDR_TEMP_READ 8'h1f
// Reset values.
`define GOTC_RST_GAIN_CONTROL 8'h84
`define GOTC_RST_OFFSET 8'h80
`define GOTC_RST_GAIN_RATIO 8'h80
`define GOTC_RST_FINE_GAIN 8'h06
`define GOTC_RST_MODE 8'h00
`define GOTC_RST_TEMP 4'h7
// Field positions.
`define GOTC_BIT_UPDATE_SELECT 7
`define GOTC_BIT_ANALOG_GAIN 6
`define GOTC_BIT_Q_OFF 5
`define GOTC_BIT_TEMP_CORR 2
`define GOTC_BIT_SOFT_RESET 3
// Converter code limits.
`define GOTC_DAC_MIN 11'h040
`define GOTC_DAC_MAX 11'h7ff
`define GOTC_DAC_OFF 11'h000
`define GOTC_OFFSET_ZERO 8'h80
// Soft reset pulse: 50 ns, at least one 100 ns clock.
`define GOTC_SRST_NS 50
`define GOTC_CLK_NS 100
`define GOTC_SRST_CYCLES ((`GOTC_SRST_NS + `GOTC_CLK_NS - 1) / `GOTC_CLK_NS)
`endif

/* File: hdl/gotc_sync.v */
`timescale 1ns/10ps
`default_nettype none
module gotc_sync (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Data.
  input wire din,
  output reg dout
);
  reg stage1;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // gotc_sync
`default_nettype wire

/* File: hdl/gotc_dac_code.v */
`timescale 1ns/10ps
`default_nettype none
`include "gotc_defines.vh"
module gotc_dac_code (
  // Gain inputs.
  input wire [4:0] coarse_gain_code,
  input wire [3:0] fine_gain_code,
  // Channel trims.
  input wire [7:0] offset_trim_value,
  input wire [7:0] gain_ratio_value,
  input wire is_i_channel,
  input wire channel_off,
  // Codes.
  output reg [10:0] pos_code,
  output reg [10:0] neg_code
);
  reg [10:0] base;
  reg [21:0] scaled;
  reg [21:0] ratioed;
  reg signed [12:0] off;
  reg signed [13:0] p;
  reg signed [13:0] n;
  // The base is 2047 * 10^(-dB/20) to within two codes; the hardwired coarse table.
  always @* begin
    base = 11'h000;
    case (coarse_gain_code)
      5'h00: base = 11'h7ff;
      5'h01: base = 11'h720;
      5'h02: base = 11'h65a;
      5'h03: base = 11'h5a9;
      5'h04: base = 11'h50c;
      5'h05: base = 11'h480;
      5'h06: base = 11'h402;
      5'h07: base = 11'h393;
      5'h08: base = 11'h32f;
      5'h09: base = 11'h2d6;
      5'h0a: base = 11'h287;
      5'h0b: base = 11'h241;
      5'h0c: base = 11'h202;
      5'h0d: base = 11'h1ca;
      5'h0e: base = 11'h199;
      5'h0f: base = 11'h16c;
      5'h10: base = 11'h144;
      5'h11: base = 11'h120;
      5'h12: base = 11'h101;
      5'h13: base = 11'h0e5;
      default: base = 11'h0e5;
    endcase
    // Each fine step trims about 0.1 dB, 1.15 percent, or 3/256.
    // Even the smallest base keeps neighbouring steps at least two codes apart here.
    scaled = {11'h000, base} * (22'h000100 - {18'h00000, fine_gain_code} * 22'h000003);
    ratioed = {11'h000, scaled[18:8]} * {14'h0000, (is_i_channel ? gain_ratio_value : 8'h80)};
    off = $signed({5'h00, offset_trim_value}) - $signed({5'h00, `GOTC_OFFSET_ZERO});
    // A ratio above 128 can lift the product past full scale, so keep the top bit for the clamp.
    p = $signed({2'h0, ratioed[18:7]}) + off;
    n = $signed({2'h0, ratioed[18:7]}) - off;
    // Shutdown code 0, otherwise clamp into 64..2047.
    if (channel_off) begin
      pos_code = `GOTC_DAC_OFF;
      neg_code = `GOTC_DAC_OFF;
    end else begin
      pos_code = (p < 14'sd64) ? `GOTC_DAC_MIN : (p > 14'sd2047) ? `GOTC_DAC_MAX : p[10:0];
      neg_code = (n < 14'sd64) ? `GOTC_DAC_MIN : (n > 14'sd2047) ? `GOTC_DAC_MAX : n[10:0];
    end
  end
endmodule // gotc_dac_code
`default_nettype wire

/* File: tb/gotc_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module gotc_checker (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Pins.
  input wire enable_pin,
  input wire thermo_update_strobe,
  input wire analog_gain_on,
  // Register port.
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Codes.
  input wire [10:0] i_positive_input,
  input wire [10:0] i_negative_input,
  input wire [10:0] q_positive_input,
  input wire [10:0] q_negative_input
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire [10:0] all_codes = i_positive_input | i_negative_input | q_positive_input | q_negative_input;
  // A write only counts once the enable synchroniser has settled.
  sequence s_wr(a);
    enable_pin [*4] ##0 (reg_write && reg_addr == a);
  endsequence
  property p_fell;
    $fell(rst) |-> all_codes == 11'h000 && !analog_gain_on;
  endproperty
  a_fell: assert property (p_fell) else $error("codes not cleared by reset");
  property p_off;
    !enable_pin [*6] |-> all_codes == 11'h000;
  endproperty
  a_off: assert property (p_off) else $error("codes live while disabled");
  property p_qoff;
    s_wr(8'h01) ##0 reg_wdata[5] |-> ##2 (q_positive_input | q_negative_input) == 11'h000;
  endproperty
  a_qoff: assert property (p_qoff) else $error("q codes not off");
  property p_agc;
    s_wr(8'h01) |-> ##2 analog_gain_on == $past(reg_wdata[6], 2);
  endproperty
  a_agc: assert property (p_agc) else $error("analog gain enable wrong");
  property p_zero;
    s_wr(8'h02) ##0 reg_wdata == 8'h80 |-> ##2 i_positive_input == i_negative_input;
  endproperty
  a_zero: assert property (p_zero) else $error("offset at midpoint");
  property p_trim;
    s_wr(8'h02) ##0 reg_wdata != 8'h80 |-> ##2 i_positive_input != i_negative_input;
  endproperty
  a_trim: assert property (p_trim) else $error("offset not split");
  property p_gap;
    reg_addr == 8'h10 |=> reg_rdata == 8'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("unmapped read nonzero");
  property p_srst;
    s_wr(8'h08) ##0 reg_wdata[3] |-> ##3 !analog_gain_on;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset missed");
  c_qoff: cover property (s_wr(8'h01) ##0 reg_wdata[5]);
  c_strobe: cover property ($rose(thermo_update_strobe));
  c_off: cover property (!enable_pin [*6]);
endmodule // gotc_checker
bind gotc_top gotc_checker u_gotc_checker (.clock(clock), .rst(rst), .enable_pin(enable_pin),
  .thermo_update_strobe(thermo_update_strobe), .analog_gain_on(analog_gain_on), .reg_write(reg_write),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .i_positive_input(i_positive_input),
  .i_negative_input(i_negative_input), .q_positive_input(q_positive_input), .q_negative_input(q_negative_input));
`default_nettype wire

/* File: tb/gotc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module gotc_host (
  // Clock.
  input wire logic clock,
  // Register port.
  output logic reg_write,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Callers keep coarse codes below 20 and offsets nonzero.
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    v = reg_rdata;
  endtask
endmodule // gotc_host
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, rst, enable_pin, thermo_update_strobe, reg_write, analog_gain_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [3:0] thermo_live_code;
  logic [10:0] i_pos, i_neg, q_pos, q_neg, prev;
  int failures = 0;
  int compares = 0;
  gotc_top u_gotc_top (.clock(clock), .rst(rst), .enable_pin(enable_pin), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .thermo_live_code(thermo_live_code),
    .thermo_update_strobe(thermo_update_strobe), .analog_gain_on(analog_gain_on), .i_positive_input(i_pos),
    .i_negative_input(i_neg), .q_positive_input(q_pos), .q_negative_input(q_neg));
  gotc_host u_gotc_host (.clock(clock), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task check(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    u_gotc_host.wr(a, v);
    repeat (2) @(posedge clock);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    u_gotc_host.rd(a, d);
    check({3'h0, d}, {3'h0, e});
  endtask
  // The strobe is held for several cycles so the synchroniser cannot miss it.
  task strobe(input logic [3:0] t);
    @(posedge clock) thermo_live_code <= t;
    repeat (8) @(posedge clock);
    thermo_update_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    thermo_update_strobe <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task t_defaults;
    rdc(8'h01, 8'h84);
    rdc(8'h02, 8'h80);
    rdc(8'h03, 8'h80);
    rdc(8'h04, 8'h80);
    rdc(8'h07, 8'h06);
    rdc(8'h08, 8'h00);
    rdc(8'h1f, 8'h07);
    rdc(8'h10, 8'h00);
    $display("defaults done");
  endtask
  task t_gain;
    wr(8'h07, 8'h00);
    wr(8'h01, 8'h80);
    check(i_pos, 11'h7ff);
    for (int k = 1; k < 20; k++) begin
      prev = i_pos;
      wr(8'h01, 8'h80 | 8'(k));
      check(11'(i_pos < prev && i_pos >= 11'h040), 11'h001);
      check(11'(q_pos == i_pos && i_neg == i_pos && q_neg == i_pos), 11'h001);
    end
    wr(8'h02, 8'h90);
    wr(8'h03, 8'h70);
    check(i_pos - i_neg, 11'h020);
    check(q_neg - q_pos, 11'h020);
    wr(8'h02, 8'h80);
    wr(8'h03, 8'h80);
    wr(8'h04, 8'ha0);
    check(11'(i_pos > q_pos), 11'h001);
    wr(8'h04, 8'h80);
    wr(8'h01, 8'hf3);
    check(q_pos | q_neg, 11'h000);
    check({10'h000, analog_gain_on}, 11'h001);
    wr(8'h01, 8'h93);
    check(11'(q_pos >= 11'h040), 11'h001);
    $display("gain done");
  endtask
  task t_thermo;
    rdc(8'h1f, 8'h07);
    strobe(4'h3);
    rdc(8'h1f, 8'h03);
    @(posedge clock) thermo_live_code <= 4'h9;
    repeat (8) @(posedge clock);
    rdc(8'h1f, 8'h03);
    wr(8'h01, 8'h13);
    repeat (6) @(posedge clock);
    rdc(8'h1f, 8'h09);
    wr(8'h01, 8'h93);
    rdc(8'h1f, 8'h03);
    wr(8'h01, 8'h80);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h04);
    check(11'(i_pos < 11'h7ff), 11'h001);
    @(posedge clock) thermo_live_code <= 4'h0;
    repeat (8) @(posedge clock);
    check(11'(i_pos < 11'h7ff), 11'h001);
    strobe(4'h0);
    check(i_pos, 11'h7ff);
    rdc(8'h1f, 8'h03);
    $display("thermo done");
  endtask
  task t_reset;
    wr(8'h01, 8'h53);
    wr(8'h08, 8'h08);
    rdc(8'h08, 8'h00);
    rdc(8'h01, 8'h84);
    check({10'h000, analog_gain_on}, 11'h000);
    @(posedge clock) enable_pin <= 1'b0;
    repeat (8) @(posedge clock);
    check(i_pos | q_pos, 11'h000);
    u_gotc_host.wr(8'h01, 8'h00);
    enable_pin <= 1'b1;
    repeat (8) @(posedge clock);
    rdc(8'h01, 8'h84);
    rdc(8'h1f, 8'h07);
    $display("reset done");
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    enable_pin = 1'b1;
    thermo_update_strobe = 1'b0;
    thermo_live_code = 4'h3;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    t_defaults;
    t_gain;
    t_thermo;
    t_reset;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
